// *** hw/jtp_defines.svh ***
// Purpose: Named constants for the test and emulation port.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef JTP_DEFINES_SVH
`define JTP_DEFINES_SVH
`define JTP_IR_WIDTH      4
`define JTP_IR_RESET      4'h1
`define JTP_IR_BYPASS     4'hf
`define JTP_IR_EMU_CTRL   4'h8
`define JTP_IR_IDCODE     4'h1
`define JTP_IR_CAPTURE    4'h1
`define JTP_EMU_DR_WIDTH  4
`define JTP_ID_WIDTH      32
`endif

// *** hw/jtp_pkg.sv ***
// Purpose: Types shared by the test and emulation port files.
// Assumes: Nothing beyond the defines header.
// Notes:   Pin groups travel as packed structs.
package jtp_pkg;
    typedef enum logic [3:0] {
        JTP_RESET, JTP_IDLE, JTP_SEL_DR, JTP_CAP_DR, JTP_SHIFT_DR,
        JTP_EXIT1_DR, JTP_PAUSE_DR, JTP_EXIT2_DR, JTP_UPD_DR,
        JTP_SEL_IR, JTP_CAP_IR, JTP_SHIFT_IR, JTP_EXIT1_IR,
        JTP_PAUSE_IR, JTP_EXIT2_IR, JTP_UPD_IR
    } jtp_tap_e;

    // One two-way emulation pin as three signals
    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } jtp_pin_s;
endpackage

// *** hw/jtp_sync.sv ***
// Purpose: Two-flop level synchroniser into the system clock domain.
// Assumes: Input is a level from another clock domain.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/10ps
module jtp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // Two flops settle metastability before any logic reads the level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // jtp_sync

// *** hw/jtp_port.sv ***
// Purpose: Scan test and emulation port of the device.
// Assumes: Test clock is a clock port; test reset is active low.
// Notes:   Status towards the core crosses into clk by two flops.
//          Two clock domains live here. The test clock runs the TAP,
//          the instruction register, the shared data shifter, the
//          emulation control bits and the serial output. The system
//          clock runs only the core-side status outputs.
//          Test reset is a level, not a clock. Low holds every test
//          clock register in reset, so the port is inert and the core
//          keeps running functionally whatever the pins do.
//          The TAP follows the usual sixteen-state walk. Mode select
//          is sampled on the test clock rise; the serial output is
//          launched on the fall, so a debugger that samples on the
//          rise sees a settled bit half a period later.
//          The serial output enable follows the shift states only.
//          Outside them the pin floats and a board pull can own it.
//          Instruction codes: identity, emulation control, and every
//          other code acts as a one-bit bypass stage.
//          The identity word loads on capture and shifts out first
//          bit first. Its value is a parameter and is arbitrary.
//          The emulation control register holds four bits. Bits 1:0
//          are the drive enables of the two pins and bits 3:2 their
//          drive levels. Capture returns the pin levels in bits 3:2
//          and the present enables in bits 1:0, so the debugger can
//          read back the direction it set together with the wires.
//          A driven pin carries the scanned level ORed with the core
//          interrupt, so either side can signal on an output pin.
//          A released pin is an incoming interrupt. Its level goes
//          to the core straight from the pin through three system
//          clock flops, because the test clock may stand still
//          between frames and must not gate the interrupt path.
//          The strap for boundary scan is caught once, on the rising
//          edge of test reset. It cannot be synchronised, since it is
//          a single event; the pins are expected to be steady well
//          before and after that edge. The latch clears on system
//          reset or on a later test reset rise without the strap.
//          Boundary-scan mode towards the core is the latch gated by
//          test reset, so it drops three system clock edges after test reset falls.
//          The internal pull enable stays on at all times after
//          reset; this is the simplest way to keep it on in
//          boundary-scan mode, traded against a later power saving.
//          Limitation: every core-side output lags its source by
//          three system clock edges, the last of them after the crossing.
//          Limitation: values scanned into the control register are
//          only seen by the core while test reset stays high.
//          Hazard: the status word crosses bit by bit. The interrupt
//          bits are ANDed with the test reset bit after the crossing,
//          so a skew of one cycle between them can reach the core as a one-cycle interrupt pulse.
`timescale 1ns/10ps
`include "jtp_defines.svh"
module jtp_port #(
    parameter logic [`JTP_ID_WIDTH-1:0] ID_CODE = 32'h1234_5671 // Arbitrary
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            tck,
    input  wire logic            trst,
    input  wire logic            tms,
    input  wire logic            tdi,
    output logic                 tdo,
    output logic                 tdo_oe,
    input  wire logic            emulation_pin_zero_in,
    output logic                 emulation_pin_zero_out,
    output logic                 emulation_pin_zero_oe,
    input  wire logic            emulation_pin_one_in,
    output logic                 emulation_pin_one_out,
    output logic                 emulation_pin_one_oe,
    input  wire logic [1:0]      core_emu_irq,
    output logic [1:0]           emu_irq_to_core,
    output logic                 scan_control,
    output logic                 boundary_scan_mode,
    output logic                 pulls_enable
);
    import jtp_pkg::*;

    jtp_tap_e                       state;
    jtp_tap_e                       next_state;
    logic [`JTP_IR_WIDTH-1:0]       ir_shift;
    logic [`JTP_IR_WIDTH-1:0]       ir;
    logic [`JTP_ID_WIDTH-1:0]       dr_shift;
    logic [`JTP_EMU_DR_WIDTH-1:0]   emu_ctrl;
    logic                           bscan_latched;
    logic [1:0]                     emu_in_s1;
    logic [1:0]                     emu_in_tck;
    logic [1:0]                     pin_in_raw;
    logic [1:0]                     pin_oe;
    logic [1:0]                     pin_out;
    logic [1:0]                     irq_in;
    logic [1:0]                     core_irq_tck_s1;
    logic [1:0]                     core_irq_tck;
    logic                           shift_state;
    logic [3:0]                     status_tck;
    logic [3:0]                     status_clk;
    jtp_pin_s                       pin0;
    jtp_pin_s                       pin1;

    // TAP next-state decode from the mode select input
    always_comb begin
        next_state = state;
        unique case (state)
            JTP_RESET:    next_state = tms ? JTP_RESET : JTP_IDLE;
            JTP_IDLE:     next_state = tms ? JTP_SEL_DR : JTP_IDLE;
            JTP_SEL_DR:   next_state = tms ? JTP_SEL_IR : JTP_CAP_DR;
            JTP_CAP_DR:   next_state = tms ? JTP_EXIT1_DR : JTP_SHIFT_DR;
            JTP_SHIFT_DR: next_state = tms ? JTP_EXIT1_DR : JTP_SHIFT_DR;
            JTP_EXIT1_DR: next_state = tms ? JTP_UPD_DR : JTP_PAUSE_DR;
            JTP_PAUSE_DR: next_state = tms ? JTP_EXIT2_DR : JTP_PAUSE_DR;
            JTP_EXIT2_DR: next_state = tms ? JTP_UPD_DR : JTP_SHIFT_DR;
            JTP_UPD_DR:   next_state = tms ? JTP_SEL_DR : JTP_IDLE;
            JTP_SEL_IR:   next_state = tms ? JTP_RESET : JTP_CAP_IR;
            JTP_CAP_IR:   next_state = tms ? JTP_EXIT1_IR : JTP_SHIFT_IR;
            JTP_SHIFT_IR: next_state = tms ? JTP_EXIT1_IR : JTP_SHIFT_IR;
            JTP_EXIT1_IR: next_state = tms ? JTP_UPD_IR : JTP_PAUSE_IR;
            JTP_PAUSE_IR: next_state = tms ? JTP_EXIT2_IR : JTP_PAUSE_IR;
            JTP_EXIT2_IR: next_state = tms ? JTP_UPD_IR : JTP_SHIFT_IR;
            JTP_UPD_IR:   next_state = tms ? JTP_SEL_DR : JTP_IDLE;
        endcase
    end

    // Low test reset holds the TAP in reset; functional mode ignores it
    always_ff @(posedge tck or negedge trst) begin
        if (!trst) begin
            state <= JTP_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Instruction register: capture, shift, update
    always_ff @(posedge tck or negedge trst) begin
        if (!trst) begin
            ir_shift <= `JTP_IR_RESET;
            ir       <= `JTP_IR_RESET;
        end else begin
            if (state == JTP_RESET) begin
                ir <= `JTP_IR_RESET;
            end
            if (state == JTP_CAP_IR) begin
                ir_shift <= `JTP_IR_CAPTURE;
            end else if (state == JTP_SHIFT_IR) begin
                ir_shift <= {tdi, ir_shift[`JTP_IR_WIDTH-1:1]};
            end
            if (state == JTP_UPD_IR) begin
                ir <= ir_shift;
            end
        end
    end

    // Data path: one shifter serves id, emulation control and bypass
    always_ff @(posedge tck or negedge trst) begin
        if (!trst) begin
            dr_shift <= '0;
        end else if (state == JTP_CAP_DR) begin
            unique case (ir)
                `JTP_IR_IDCODE:   dr_shift <= ID_CODE;
                `JTP_IR_EMU_CTRL: dr_shift <= {28'h0000000, emu_in_tck,
                                               emu_ctrl[1:0]};
                default:          dr_shift <= '0;
            endcase
        end else if (state == JTP_SHIFT_DR) begin
            unique case (ir)
                `JTP_IR_IDCODE:   dr_shift <= {tdi,
                                     dr_shift[`JTP_ID_WIDTH-1:1]};
                `JTP_IR_EMU_CTRL: dr_shift <= {28'h0000000, tdi,
                                     dr_shift[`JTP_EMU_DR_WIDTH-1:1]};
                default:          dr_shift <= {31'h00000000, tdi};
            endcase
        end
    end

    // Emulation control: bits 1:0 drive enables, bits 3:2 drive levels
    always_ff @(posedge tck or negedge trst) begin
        if (!trst) begin
            emu_ctrl <= '0;
        end else if (state == JTP_UPD_DR && ir == `JTP_IR_EMU_CTRL) begin
            emu_ctrl <= dr_shift[`JTP_EMU_DR_WIDTH-1:0];
        end
    end

    // Emulation pins are asynchronous to the test clock: two flops each
    // before the capture path reads them
    always_ff @(posedge tck or negedge trst) begin
        if (!trst) begin
            emu_in_s1       <= '0;
            emu_in_tck      <= '0;
            core_irq_tck_s1 <= '0;
            core_irq_tck    <= '0;
        end else begin
            emu_in_s1       <= pin_in_raw;
            emu_in_tck      <= emu_in_s1;
            core_irq_tck_s1 <= core_emu_irq;
            core_irq_tck    <= core_irq_tck_s1;
        end
    end

    // Strap sampled at the test reset rise: the first edge after release
    // sees the raw pins, since it is a level caught once, not a stream
    always_ff @(posedge trst or posedge rst) begin
        if (rst) begin
            bscan_latched <= 1'b0;
        end else begin
            bscan_latched <= emulation_pin_zero_in
                             & ~emulation_pin_one_in;
        end
    end

    // Output changes on the falling test clock edge
    assign shift_state = (state == JTP_SHIFT_DR) || (state == JTP_SHIFT_IR);
    always_ff @(negedge tck or negedge trst) begin
        if (!trst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= (state == JTP_SHIFT_IR) ? ir_shift[0]
                                              : dr_shift[0];
            tdo_oe <= shift_state;
        end
    end

    // Raw pin levels gathered into one vector for the per-pin loop
    assign pin_in_raw = {emulation_pin_one_in, emulation_pin_zero_in};

    // One driver per emulation pin; only active under scan control.
    // The incoming interrupt is the raw pin while the pin is released.
    for (genvar g = 0; g < 2; g++) begin : g_pin
        assign pin_oe[g]  = trst & emu_ctrl[g];
        assign pin_out[g] = emu_ctrl[g+2] | core_irq_tck[g];
        assign irq_in[g]  = pin_in_raw[g] & ~emu_ctrl[g];
    end

    // Pin groups packed for the carrier
    always_comb begin
        pin0.in  = pin_in_raw[0];
        pin0.oe  = pin_oe[0];
        pin0.out = pin_out[0];
        pin1.in  = pin_in_raw[1];
        pin1.oe  = pin_oe[1];
        pin1.out = pin_out[1];
    end
    assign emulation_pin_zero_oe  = pin0.oe;
    assign emulation_pin_zero_out = pin0.out;
    assign emulation_pin_one_oe   = pin1.oe;
    assign emulation_pin_one_out  = pin1.out;

    // Status gathered for the crossing; incoming pins act as interrupts.
    // Pins go straight to the crossing: a stopped test clock must not
    // freeze an interrupt on its way to the core.
    assign status_tck = {bscan_latched & trst, trst, irq_in};

    // Levels into the system clock domain; trst itself is a plain level
    jtp_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (status_tck),
        .dout (status_clk)
    );

    // Core-side outputs registered after the crossing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_control       <= 1'b0;
            boundary_scan_mode <= 1'b0;
            pulls_enable       <= 1'b1;
            emu_irq_to_core    <= '0;
        end else begin
            scan_control       <= status_clk[2];
            boundary_scan_mode <= status_clk[3];
            pulls_enable       <= 1'b1;
            emu_irq_to_core    <= status_clk[1:0] & {2{status_clk[2]}};
        end
    end
endmodule // jtp_port

// *** sim/jtp_port_props.sv ***
// Purpose: Port checker for the test and emulation port.
// Assumes: Bound to jtp_port; sees its ports only.
// Notes:   Sampled on clk so test-clock edges are seen too.
`timescale 1ns/10ps
module jtp_port_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       tck,
    input wire logic       trst,
    input wire logic       tdo,
    input wire logic       tdo_oe,
    input wire logic       emulation_pin_zero_in,
    input wire logic       emulation_pin_zero_oe,
    input wire logic       emulation_pin_one_oe,
    input wire logic [1:0] emu_irq_to_core,
    input wire logic       scan_control,
    input wire logic       boundary_scan_mode,
    input wire logic       pulls_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Pin zero left to the emulator and high long enough to cross
    sequence s_pin0_req;
        (trst && !emulation_pin_zero_oe && emulation_pin_zero_in) [*6];
    endsequence
    sequence s_test_start;
        $rose(trst);
    endsequence
    a_scan_take: assert property (s_test_start |-> ##[1:5] scan_control)
        else $error("scan control not taken");
    a_scan_drop: assert property ($fell(trst) |-> ##[1:5] !scan_control)
        else $error("scan control kept");
    a_bscan_drop: assert property ($fell(trst) |-> ##[0:5] !boundary_scan_mode)
        else $error("boundary scan kept");
    a_tdo_fall: assert property (disable iff (rst || !trst)
        $changed(tdo) |-> $fell(tck)) else $error("tdo moved off fall");
    a_tdo_release: assert property (!trst |-> !tdo_oe)
        else $error("tdo driven in functional mode");
    a_tdo_quiet: assert property (s_test_start |-> !tdo_oe [*4])
        else $error("tdo driven outside shift");
    a_emu_release: assert property (!trst |->
        !emulation_pin_zero_oe && !emulation_pin_one_oe)
        else $error("emulation pin driven");
    a_irq_in: assert property (s_pin0_req |-> emu_irq_to_core[0])
        else $error("incoming emulation interrupt lost");
    a_pulls_on: assert property (boundary_scan_mode |-> pulls_enable)
        else $error("pulls off in boundary scan");
endmodule // jtp_port_props

bind jtp_port jtp_port_props u_props (.clk(clk), .rst(rst), .tck(tck),
    .trst(trst), .tdo(tdo), .tdo_oe(tdo_oe),
    .emulation_pin_zero_in(emulation_pin_zero_in),
    .emulation_pin_zero_oe(emulation_pin_zero_oe),
    .emulation_pin_one_oe(emulation_pin_one_oe),
    .emu_irq_to_core(emu_irq_to_core), .scan_control(scan_control),
    .boundary_scan_mode(boundary_scan_mode), .pulls_enable(pulls_enable));

// *** sim/jtp_dbg.sv ***
// Purpose: Debugger model driving the test clock side.
// Assumes: Test clock 125 ns, idle low between frames.
// Notes:   Returned words are right aligned, first bit in bit 0.
`timescale 1ns/10ps
module jtp_dbg (
    output logic        tck,
    output logic        trst,
    output logic        tms,
    output logic        tdi,
    input  wire logic   tdo,
    output logic [31:0] cap,
    output logic        got
);
    initial begin
        tck = 1'b0;
        trst = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        cap = 32'h0;
        got = 1'b0;
    end
    // Test reset moves only while the clock stands still
    task automatic set_trst(input logic v);
        #20 trst = v;
        #20;
    endtask
    // One test clock; tdo taken on the rise, while it is stable
    task automatic step(input logic m, input logic d, input logic smp);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        if (smp) cap = {tdo, cap[31:1]};
        #62.5 tck = 1'b0;
    endtask
    // Idle to shift, n bits, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] d);
        step(1'b1, 1'b1, 1'b0);
        if (ir) step(1'b1, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) step(i == n - 1, d[i], 1'b1);
        step(1'b1, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        cap = cap >> (32 - n);
        got = 1'b1;
        #1 got = 1'b0;
    endtask
endmodule // jtp_dbg

// *** sim/jtp_port_tb.sv ***
// Purpose: Self-checking bench for the test and emulation port.
// Assumes: Debugger model drives the test clock side.
// Notes:   Pins have pull-ups, so released lines read high.
`timescale 1ns/10ps
module jtp_port_tb;
    localparam logic [31:0] IDV = 32'h0c3a_5e17; // Arbitrary
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  irq;
    logic        d0e = 1'b0;
    logic        d1e = 1'b0;
    logic        d1v;
    logic        tck, trst, tms, tdi, tdo, tdo_oe, got;
    logic        o0, e0, o1, e1, p0, p1, scn, bsm, pul, l0, l1;
    logic [1:0]  irqc;
    logic [31:0] cap;
    logic [31:0] exq[$];
    int          error_cnt = 0;
    int          tests_run = 0;
    logic [7:0]  lf = 8'h12;
    logic [3:0]  v, pv;
    assign p0 = e0 ? o0 : !d0e;
    assign p1 = e1 ? o1 : (d1e ? d1v : 1'b1);
    initial begin
        forever #5 clk = ~clk;
    end
    jtp_port #(.ID_CODE(IDV)) uut (.clk(clk), .rst(rst), .tck(tck),
        .trst(trst), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .emulation_pin_zero_in(p0), .emulation_pin_zero_out(o0),
        .emulation_pin_zero_oe(e0), .emulation_pin_one_in(p1),
        .emulation_pin_one_out(o1), .emulation_pin_one_oe(e1),
        .core_emu_irq(irq), .emu_irq_to_core(irqc), .scan_control(scn),
        .boundary_scan_mode(bsm), .pulls_enable(pul));
    jtp_dbg u_dbg (.tck(tck), .trst(trst), .tms(tms), .tdi(tdi),
        .tdo(tdo), .cap(cap), .got(got));
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic bad(input string m);
        error_cnt++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk_bit(input logic a, input logic e, input string m);
        tests_run++;
        if (a !== e) bad(m);
    endtask
    task automatic chk_word(input logic [31:0] a, input logic [31:0] e);
        tests_run++;
        if (a !== e) bad($sformatf("word %h want %h", a, e));
    endtask
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Each returned word is paired with the oldest note
    always @(posedge got) begin
        if (exq.size() == 0) bad("unexpected word");
        else chk_word(cap, exq.pop_front());
    end
    initial begin
        #500_000;
        bad("timeout");
        end_sim();
    end
    initial begin
        irq <= 2'b00;
        d1v <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk_bit(scn, 1'b0, "scan ctl");
        chk_bit(tdo_oe, 1'b0, "tdo drive");
        chk_bit(pul, 1'b1, "pulls");
        $display("test functional done");
        // Wrong strap first, then the boundary-scan strap
        for (int s = 0; s < 2; s++) begin
            d1e <= 1'b1;
            d1v <= ~s[0];
            repeat (2) @(posedge clk);
            u_dbg.set_trst(1'b1);
            repeat (8) @(posedge clk);
            chk_bit(scn, 1'b1, "scan ctl");
            chk_bit(bsm, s[0], "bscan");
            u_dbg.set_trst(1'b0);
            repeat (8) @(posedge clk);
            chk_bit(bsm, 1'b0, "bscan off");
        end
        $display("test strap done");
        d1e <= 1'b0;
        lf = nxt(lf);
        irq <= lf[5:4];
        u_dbg.set_trst(1'b1);
        u_dbg.step(1'b0, 1'b1, 1'b0);
        exq.push_back(IDV);
        u_dbg.scan(1'b0, 32, 32'hffff_ffff);
        exq.push_back(32'h1);
        u_dbg.scan(1'b1, 4, 32'h8);
        $display("test identity done");
        // Emulation control: directions and levels scanned in
        pv = 4'h0;
        for (int k = 0; k < 5; k++) begin
            lf = nxt(lf);
            v = (k == 4) ? 4'h0 : lf[3:0];
            l0 = pv[0] ? (pv[2] | irq[0]) : 1'b1;
            l1 = pv[1] ? (pv[3] | irq[1]) : 1'b1;
            exq.push_back({28'h0, l1, l0, pv[1:0]});
            u_dbg.scan(1'b0, 4, {28'h0, v});
            repeat (2) @(posedge clk);
            chk_bit(e0, v[0], "pin0 oe");
            chk_bit(e1, v[1], "pin1 oe");
            chk_bit(o0, v[2] | irq[0], "pin0 out");
            pv = v;
        end
        repeat (8) @(posedge clk);
        chk_word({30'h0, irqc}, 32'h3);
        d0e <= 1'b1;
        repeat (8) @(posedge clk);
        chk_word({30'h0, irqc}, 32'h2);
        $display("test emulation pins done");
        exq.push_back(32'h1);
        u_dbg.scan(1'b1, 4, 32'hf);
        exq.push_back({24'h0, lf[6:0], 1'b0});
        u_dbg.scan(1'b0, 8, {24'h0, lf});
        $display("test bypass done");
        u_dbg.set_trst(1'b0);
        repeat (8) @(posedge clk);
        chk_bit(scn, 1'b0, "scan ctl");
        chk_bit(e0 | tdo_oe, 1'b0, "released");
        chk_word(exq.size(), 32'h0);
        end_sim();
    end
endmodule // jtp_port_tb
